// ### logic/mbs_pkg.sv
/*
 * Constants and types shared by the multi-register slave: function and
 * exception codes, query field positions, frame lengths, CRC constants.
 * Assumes: byte framing and inter-frame silence are handled upstream.
 */
`default_nettype none

package mbs_pkg;
    // ------------------------------------------------------------
    // function and exception codes
    // ------------------------------------------------------------
    localparam logic [7:0] FC_WR_MULTI    = 8'h10;
    localparam logic [7:0] FC_RW_MULTI    = 8'h17;
    localparam logic [7:0] FC_EXC_FLAG    = 8'h80;
    localparam logic [7:0] EXC_ILL_FUNC   = 8'h01;
    localparam logic [7:0] EXC_NO_FUNC    = 8'h02;
    localparam logic [7:0] EXC_BAD_FORMAT = 8'h03;
    localparam logic [7:0] EXC_DATA_RANGE = 8'h21;
    localparam logic [7:0] EXC_BAD_STATE  = 8'h22;
    localparam logic [7:0] EXC_READ_ONLY  = 8'h23;
    localparam logic [7:0] BCAST_ADDR     = 8'h00;

    // ------------------------------------------------------------
    // query byte positions
    // ------------------------------------------------------------
    localparam int POS_ADDR     = 0;
    localparam int POS_FC       = 1;
    localparam int POS_A_HI     = 2;   // write start (10h) / read start (17h)
    localparam int POS_A_LO     = 3;
    localparam int POS_C_HI     = 4;   // write count (10h) / read count (17h)
    localparam int POS_C_LO     = 5;
    localparam int POS_WR_BC    = 6;
    localparam int POS_RW_WA_HI = 6;
    localparam int POS_RW_WA_LO = 7;
    localparam int POS_RW_WC_HI = 8;
    localparam int POS_RW_WC_LO = 9;
    localparam int POS_RW_BC    = 10;
    localparam int HDR_BYTES    = 11;

    // ------------------------------------------------------------
    // frame lengths (bytes before CRC)
    // ------------------------------------------------------------
    localparam logic [8:0] WR_DATA_START = 9'h007;
    localparam logic [8:0] RW_DATA_START = 9'h00B;
    localparam logic [8:0] WR_RESP_LEN   = 9'h006;
    localparam logic [8:0] EXC_RESP_LEN  = 9'h003;
    localparam logic [8:0] RW_RESP_HDR   = 9'h003;
    localparam logic [8:0] CRC_LEN       = 9'h002;
    localparam logic [8:0] MIN_FRAME     = 9'h004;

    // ------------------------------------------------------------
    // crc and parameter scaling
    // ------------------------------------------------------------
    localparam logic [15:0] CRC_INIT     = 16'hFFFF;
    localparam logic [15:0] CRC_POLY     = 16'hA001;
    localparam logic [15:0] CRC_RESIDUE  = 16'h0000;
    localparam int          ACCEL_RES_CS = 1;   // hundredths of a second per count

    typedef enum logic [2:0] {
        S_RX, S_CPR, S_CPW, S_FETCH, S_LOAD, S_SEND
    } mbs_state_t;
endpackage

`default_nettype wire

// ### logic/mbs_mem_if.sv
/*
 * Port bundle between the frame handler and its register memory.
 * Assumes: one clock; read data appear one edge after the address.
 */
`timescale 1ns/1ps
`default_nettype none

interface mbs_mem_if #(parameter int AW = 9);
    logic          we;
    logic [AW-1:0] addr;
    logic [15:0]   wdata;
    logic [15:0]   rdata;

    modport host (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// ### logic/mbs_regmem.sv
/*
 * Single-port word memory: holding registers in the low half,
 * write staging words in the high half. Read data is registered.
 * Assumes: one clock; contents are not reset.
 */
`timescale 1ns/1ps
`default_nettype none

module mbs_regmem #(
    parameter int AW = 9
) (
    // clock
    input  wire logic i_clock,
    // memory port
    mbs_mem_if.mem    bus
);
    logic [15:0] store [0:(1<<AW)-1];

    // write and registered read on the same edge; read returns the old word
    always_ff @(posedge i_clock) begin
        if (bus.we) begin
            store[bus.addr] <= bus.wdata;
        end
        bus.rdata <= store[bus.addr];
    end
endmodule

`default_nettype wire

// ### logic/mbs_slave.sv
/*
 * Frame handler for write-multiple (10h) and read-write-multiple (17h)
 * holding register queries, with exception responses.
 * Assumes: received bytes and an end-of-frame pulse arrive on this clock
 * from a UART/framing stage; transmit bytes go to a serialiser with ready.
 */
// Contract
// [R1] 10h writes data words into consecutive registers from the start address.
// [R2] write query: addr, fc, start, count, byte count, data high first, CRC.
// [R3] write answer is eight bytes: addr, fc, start, count, new CRC.
// [R4] master never broadcasts a write; only own-address queries are served.
// [R5] byte count field means data bytes, checked as twice the count.
// [R6] line address is register number minus one; zero-based addressing.
// [R7] 32-bit values use two registers, high word at the lower address.
// [R8] 17h writes one register run and reads another in one transaction.
// [R9] read-write performs the write first, then reads.
// [R10] read-write query: addr, fc, read start/count, write start/count, bc, data, CRC.
// [R11] read-write answer: addr, fc, byte count, read words high first, CRC.
// [R12] every addressed query gets a normal answer or an exception answer.
// [R13] exception answer: addr, fc, one exception code byte, CRC.
// [R14] exception function code is query code plus 80h.
// [R15] exception codes 01h, 02h, 03h, 21h, 22h, 23h by cause; the code never raises 21h.
// [R16] broadcast queries get no answer at all.
// [R17] bad CRC or foreign address frames are dropped silently.
// [R18] answer CRC is standard CRC-16 over all preceding answer bytes.
`timescale 1ns/1ps
`default_nettype none

module mbs_slave #(
    parameter int          HOLD_AW = 8,
    parameter int          MAX_WR  = 16,
    parameter int          MAX_RD  = 16,
    parameter logic [15:0] RO_BASE = 16'h00C0
) (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // configuration
    input  wire logic [7:0] i_slave_addr,
    input  wire logic       i_write_lock,
    // receive byte stream
    input  wire logic       i_rx_valid,
    input  wire logic [7:0] i_rx_data,
    input  wire logic       i_rx_end,
    // transmit byte stream
    input  wire logic       i_tx_ready,
    output logic            o_tx_valid,
    output logic [7:0]      o_tx_data,
    output logic            o_tx_last
);
    localparam int          AW    = HOLD_AW + 1;
    localparam logic [16:0] DEPTH = 17'(1 << HOLD_AW);

    // ------------------------------------------------------------
    // crc step, reflected polynomial
    // ------------------------------------------------------------
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ mbs_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    mbs_pkg::mbs_state_t state;
    logic [7:0]  hdr [0:mbs_pkg::HDR_BYTES-1];
    logic [8:0]  rx_idx;
    logic [7:0]  hi_byte;
    logic [15:0] crc;
    logic        exc;
    logic [7:0]  exc_code;
    logic [15:0] cp_cnt;
    logic        commit_done;
    logic [8:0]  tx_idx;
    logic [8:0]  tx_len;
    logic [15:0] word;

    mbs_mem_if #(.AW(AW)) mem_bus ();
    mbs_regmem #(.AW(AW)) u_mem (.i_clock(i_clock), .bus(mem_bus.mem));

    // ------------------------------------------------------------
    // query field decode
    // ------------------------------------------------------------
    wire [7:0]  fc     = hdr[mbs_pkg::POS_FC];
    wire        is_wr  = fc == mbs_pkg::FC_WR_MULTI;
    wire        is_rw  = fc == mbs_pkg::FC_RW_MULTI;
    // [R6] zero-based line address
    wire [15:0] rsa    = {hdr[mbs_pkg::POS_A_HI], hdr[mbs_pkg::POS_A_LO]};
    wire [15:0] rcnt   = {hdr[mbs_pkg::POS_C_HI], hdr[mbs_pkg::POS_C_LO]};
    // [R2] [R10] field layout per code
    wire [15:0] wsa    = is_rw ? {hdr[mbs_pkg::POS_RW_WA_HI], hdr[mbs_pkg::POS_RW_WA_LO]} : rsa;
    wire [15:0] wcnt   = is_rw ? {hdr[mbs_pkg::POS_RW_WC_HI], hdr[mbs_pkg::POS_RW_WC_LO]} : rcnt;
    wire [7:0]  bc     = is_rw ? hdr[mbs_pkg::POS_RW_BC] : hdr[mbs_pkg::POS_WR_BC];
    wire [8:0]  dstart = is_rw ? mbs_pkg::RW_DATA_START : mbs_pkg::WR_DATA_START;
    wire [8:0]  d_off  = rx_idx - dstart;
    wire [15:0] st_idx = {8'h00, d_off[8:1]};

    // ------------------------------------------------------------
    // frame checks at end of frame
    // ------------------------------------------------------------
    wire        crc_ok   = crc == mbs_pkg::CRC_RESIDUE;
    wire        addr_ok  = hdr[mbs_pkg::POS_ADDR] == i_slave_addr;
    wire        bcast    = hdr[mbs_pkg::POS_ADDR] == mbs_pkg::BCAST_ADDR;
    wire        drop     = rx_idx < mbs_pkg::MIN_FRAME || !crc_ok || bcast || !addr_ok;
    // [R5] byte count is data bytes
    wire        bc_ok    = {wcnt, 1'b0} == {9'h000, bc};
    wire        len_ok   = rx_idx == dstart + {1'b0, bc} + mbs_pkg::CRC_LEN;
    wire        wcnt_ok  = wcnt != 16'h0000 && wcnt <= 16'(MAX_WR);
    wire        rcnt_ok  = !is_rw || (rcnt != 16'h0000 && rcnt <= 16'(MAX_RD));
    wire        fmt_ok   = bc_ok && len_ok && wcnt_ok && rcnt_ok;
    wire [16:0] w_end    = {1'b0, wsa} + {1'b0, wcnt};
    wire [16:0] r_end    = {1'b0, rsa} + {1'b0, rcnt};
    wire        range_ok = w_end <= DEPTH && (!is_rw || r_end <= DEPTH);
    wire        ro_hit   = w_end > {1'b0, RO_BASE};

    // [R12] [R15] exception cause priority
    wire [7:0]  next_exc_code = !(is_wr || is_rw) ? mbs_pkg::EXC_ILL_FUNC   :
                                !fmt_ok           ? mbs_pkg::EXC_BAD_FORMAT :
                                !range_ok         ? mbs_pkg::EXC_NO_FUNC    :
                                ro_hit            ? mbs_pkg::EXC_READ_ONLY  :
                                i_write_lock      ? mbs_pkg::EXC_BAD_STATE  : 8'h00;
    wire        next_exc  = next_exc_code != 8'h00;
    wire        frame_end = state == mbs_pkg::S_RX && i_rx_end;

    // ------------------------------------------------------------
    // memory port select
    // ------------------------------------------------------------
    wire        rx_take   = state == mbs_pkg::S_RX && i_rx_valid && !i_rx_end;
    wire        stage_we  = rx_take && rx_idx >= dstart && d_off < 9'(2 * MAX_WR) && d_off[0];
    wire [8:0]  rd_off    = tx_idx - mbs_pkg::RW_RESP_HDR;
    wire [15:0] rd_word   = {8'h00, rd_off[8:1]};
    wire [15:0] hold_wa   = wsa + cp_cnt;
    wire [15:0] hold_ra   = rsa + rd_word;
    assign mem_bus.we    = stage_we || state == mbs_pkg::S_CPW;
    assign mem_bus.wdata = state == mbs_pkg::S_CPW ? mem_bus.rdata : {hi_byte, i_rx_data};
    assign mem_bus.addr  = state == mbs_pkg::S_CPR   ? {1'b1, cp_cnt[HOLD_AW-1:0]}  :
                           state == mbs_pkg::S_CPW   ? {1'b0, hold_wa[HOLD_AW-1:0]} :
                           state == mbs_pkg::S_FETCH ? {1'b0, hold_ra[HOLD_AW-1:0]} :
                                                       {1'b1, st_idx[HOLD_AW-1:0]};

    // ------------------------------------------------------------
    // answer byte select
    // ------------------------------------------------------------
    wire        data_area = is_rw && !exc && tx_idx >= mbs_pkg::RW_RESP_HDR && tx_idx < tx_len;
    wire [7:0]  rw_bc     = {rcnt[6:0], 1'b0};
    wire [7:0]  next_byte =
        tx_idx == tx_len                                ? crc[7:0]  :
        tx_idx == tx_len + 9'h001                       ? crc[15:8] :
        tx_idx == 9'h000                                ? hdr[mbs_pkg::POS_ADDR] :
        tx_idx == 9'h001                                ? (exc ? fc | mbs_pkg::FC_EXC_FLAG : fc) :
        exc                                             ? exc_code :
        data_area                                       ? (rd_off[0] ? word[7:0] : mem_bus.rdata[15:8]) :
        is_rw                                           ? rw_bc :
                                                          hdr[tx_idx[3:0]];
    wire [8:0]  tx_nidx    = tx_idx + 9'h001;
    wire        next_fetch = is_rw && !exc && tx_nidx >= mbs_pkg::RW_RESP_HDR && tx_nidx < tx_len
                             && rd_off[0];   // fetch ahead of each high byte
    wire        last_byte  = tx_idx == tx_len + 9'h001;

    // ------------------------------------------------------------
    // receive, commit and answer sequencing
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= mbs_pkg::S_RX;
            for (int i = 0; i < mbs_pkg::HDR_BYTES; i++) begin
                hdr[i] <= 8'h00;
            end
            rx_idx <= 9'h000;  hi_byte <= 8'h00;  crc <= mbs_pkg::CRC_INIT;
            exc <= 1'b0;  exc_code <= 8'h00;  cp_cnt <= 16'h0000;  commit_done <= 1'b0;
            tx_idx <= 9'h000;  tx_len <= 9'h000;  word <= 16'h0000;
            o_tx_valid <= 1'b0;  o_tx_data <= 8'h00;  o_tx_last <= 1'b0;
        end else begin
            case (state)
                mbs_pkg::S_RX: begin
                    if (i_rx_end) begin
                        // [R17] [R16] drop silently
                        if (drop) begin
                            rx_idx <= 9'h000;
                            crc    <= mbs_pkg::CRC_INIT;
                        end else begin
                            exc      <= next_exc;
                            exc_code <= next_exc_code;
                            cp_cnt   <= 16'h0000;
                            tx_idx   <= 9'h000;
                            crc      <= mbs_pkg::CRC_INIT;
                            tx_len   <= next_exc ? mbs_pkg::EXC_RESP_LEN :
                                        is_rw ? mbs_pkg::RW_RESP_HDR + {1'b0, rw_bc} :
                                        mbs_pkg::WR_RESP_LEN;
                            state    <= next_exc ? mbs_pkg::S_LOAD : mbs_pkg::S_CPR;
                        end
                    end else if (i_rx_valid) begin
                        crc <= crc_step(crc, i_rx_data);
                        if (rx_idx != 9'h1FF) begin
                            rx_idx <= rx_idx + 9'h001;
                        end
                        if (rx_idx < 9'(mbs_pkg::HDR_BYTES)) begin
                            hdr[rx_idx[3:0]] <= i_rx_data;
                        end
                        hi_byte <= i_rx_data;
                    end
                end
                // [R1] [R7] [R8] copy staged words upward in address order
                mbs_pkg::S_CPR: state <= mbs_pkg::S_CPW;
                mbs_pkg::S_CPW: begin
                    cp_cnt <= cp_cnt + 16'h0001;
                    if (cp_cnt + 16'h0001 == wcnt) begin
                        commit_done <= 1'b1;
                        state       <= mbs_pkg::S_LOAD;
                    end else begin
                        state <= mbs_pkg::S_CPR;
                    end
                end
                // [R9] read only after the commit
                mbs_pkg::S_FETCH: state <= mbs_pkg::S_LOAD;
                // [R3] [R11] [R13] [R14] [R18] present one answer byte
                mbs_pkg::S_LOAD: begin
                    o_tx_valid <= 1'b1;
                    o_tx_data  <= next_byte;
                    o_tx_last  <= last_byte;
                    word       <= mem_bus.rdata;
                    if (tx_idx < tx_len) begin
                        crc <= crc_step(crc, next_byte);
                    end
                    state <= mbs_pkg::S_SEND;
                end
                mbs_pkg::S_SEND: begin
                    if (i_tx_ready) begin
                        o_tx_valid <= 1'b0;
                        o_tx_last  <= 1'b0;
                        tx_idx     <= tx_nidx;
                        if (o_tx_last) begin
                            rx_idx      <= 9'h000;
                            crc         <= mbs_pkg::CRC_INIT;
                            commit_done <= 1'b0;
                            state       <= mbs_pkg::S_RX;
                        end else begin
                            state <= next_fetch ? mbs_pkg::S_FETCH : mbs_pkg::S_LOAD;
                        end
                    end
                end
                default: state <= mbs_pkg::S_RX;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_frame_ok;
        frame_end && !drop;
    endsequence
    sequence s_frame_bad;
        frame_end && drop;
    endsequence

    drop_silent_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R17]
        s_frame_bad |=> state == mbs_pkg::S_RX && !o_tx_valid)
        else $error("dropped frame left receive");
    bcast_mute_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R16]
        (frame_end && bcast) |=> (!o_tx_valid) [*3])
        else $error("broadcast answered");
    bc_format_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R5]
        (s_frame_ok and (is_wr || is_rw) && !bc_ok) |=> exc && exc_code == mbs_pkg::EXC_BAD_FORMAT)
        else $error("byte count mismatch not flagged");
    bad_func_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R15]
        (s_frame_ok and !is_wr && !is_rw) |=> exc && exc_code == mbs_pkg::EXC_ILL_FUNC)
        else $error("unsupported code not flagged");
    exc_code_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R14]
        (state == mbs_pkg::S_LOAD && exc && tx_idx == 9'h001) |=> o_tx_data == (fc | 8'h80))
        else $error("exception code not offset");
    wr_len_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R3]
        (state == mbs_pkg::S_LOAD && is_wr && !exc) |-> tx_len == 9'h006)
        else $error("write answer length wrong");
    commit_wr_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R1]
        (state == mbs_pkg::S_CPR) |=> mem_bus.we && mem_bus.addr[HOLD_AW] == 1'b0
            && mem_bus.addr[HOLD_AW-1:0] == hold_wa[HOLD_AW-1:0])
        else $error("commit write misplaced");
    write_first_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R9]
        (state == mbs_pkg::S_FETCH) |-> commit_done && cp_cnt == wcnt)
        else $error("read before write finished");
    tx_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R11]
        (o_tx_valid && !i_tx_ready) |=> o_tx_valid && $stable(o_tx_data))
        else $error("answer byte dropped");
    answer_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [R12]
        s_frame_ok |-> ##[1:80] o_tx_valid)
        else $error("addressed query not answered");
endmodule

`default_nettype wire

// ### test/mbs_master_model.sv
/* Master side of the serial link: sends query bytes, collects answer bytes.
   Assumes: slave runs on the same clock with a valid/ready answer stream. */
`timescale 1ns/1ps
`default_nettype none
module mbs_master_model (
    // clock and pacing
    input  wire logic       i_clock,
    input  wire logic       i_slow,
    // answer stream
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_tx_last,
    // query stream
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_data,
    output logic            o_rx_end,
    output logic            o_tx_ready
);
    logic [7:0] resp[$];
    logic       got_last = 1'b0;
    logic [1:0] pace = 2'h0;
    initial o_rx_valid = 1'b0;
    initial o_rx_data = 8'h5A;
    initial o_rx_end = 1'b0;
    initial o_tx_ready = 1'b0;
    // bytes in caller order, then end pulse
    task automatic send_frame(input logic [7:0] q[$]);
        resp.delete();
        got_last = 1'b0;
        foreach (q[i]) begin
            @(posedge i_clock);
            o_rx_valid <= 1'b1;
            o_rx_data  <= q[i];
        end
        @(posedge i_clock);
        o_rx_valid <= 1'b0;
        o_rx_data  <= ~o_rx_data;
        o_rx_end   <= 1'b1;
        @(posedge i_clock);
        o_rx_end   <= 1'b0;
        o_rx_data  <= ~o_rx_data;
    endtask
    // ready pacing, stalls in slow mode; bytes taken at handshake
    always @(posedge i_clock) begin
        pace <= pace + 2'h1;
        o_tx_ready <= !i_slow || (pace == 2'h0);
        if (i_tx_valid && o_tx_ready) begin
            resp.push_back(i_tx_data);
            if (i_tx_last) got_last <= 1'b1;
        end
    end
    // wait for the last answer byte, bounded
    task automatic get_resp(output logic [7:0] q[$]);
        int n;
        n = 0;
        while (!got_last && n < 600) begin
            @(posedge i_clock);
            n++;
        end
        @(posedge i_clock);
        q = resp;
    endtask
endmodule
`default_nettype wire

// ### test/modbus_multi_register_slave_tb_top.sv
/* Bench for the multi-register slave: queries through the master model,
   every answer compared with a queue-based reference.
   Assumes: package and memory interface compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp); end end
module modbus_multi_register_slave_tb_top;
    logic        i_clock = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [7:0]  slave_addr = 8'h08;
    logic        write_lock = 1'b0;
    logic        slow = 1'b0;
    logic        rx_valid, rx_end, tx_ready, tx_valid, tx_last;
    logic [7:0]  rx_data, tx_data;
    logic [31:0] rng = 32'h6176;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          mem[256];
    // exception cases: code, address, count, byte count skew, lock, expected
    logic [7:0]  xfc[7] = '{8'h03, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h17};
    logic [15:0] xwa[7] = '{16'h0010, 16'h0010, 16'h0010, 16'h00FF, 16'h00C4, 16'h0010, 16'h0010};
    int          xwc[7] = '{1, 1, 0, 2, 2, 1, 1};
    int          xbc[7] = '{0, 1, 0, 0, 0, 0, 0};
    logic        xlk[7] = '{0, 0, 0, 0, 0, 1, 1};
    logic [7:0]  xex[7] = '{8'h01, 8'h03, 8'h03, 8'h02, 8'h23, 8'h22, 8'h22};
    always #2 i_clock = ~i_clock;
    mbs_slave mbs_slave_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_slave_addr(slave_addr),
        .i_write_lock(write_lock), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
        .i_rx_end(rx_end), .i_tx_ready(tx_ready), .o_tx_valid(tx_valid),
        .o_tx_data(tx_data), .o_tx_last(tx_last));
    mbs_master_model mbs_master_model_inst (.i_clock(i_clock), .i_slow(slow),
        .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_tx_last(tx_last),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_end(rx_end), .o_tx_ready(tx_ready));
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // reflected crc, low byte first on the line
    task automatic add_crc(inout logic [7:0] q[$]);
        logic [15:0] c;
        c = mbs_pkg::CRC_INIT;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ mbs_pkg::CRC_POLY) : (c >> 1);
        end
        q = {q, c[7:0], c[15:8]};
    endtask
    task automatic mk(input logic [7:0] fc, input logic [15:0] hw[$], input logic [15:0] dw[$],
                      input int bcadj, output logic [7:0] q[$]);
        q = {slave_addr, fc};
        foreach (hw[i]) q = {q, hw[i][15:8], hw[i][7:0]};
        q.push_back(8'(dw.size() * 2 + bcadj));
        foreach (dw[i]) q = {q, dw[i][15:8], dw[i][7:0]};
        add_crc(q);
    endtask
    task automatic model(input logic [7:0] q[$], input logic [7:0] ex, output logic [7:0] r[$]);
        int wa, wc, ra, rc;
        ra = int'({q[2], q[3]});
        rc = int'({q[4], q[5]});
        r = {q[0], q[1], 8'(2 * rc)};
        if (ex != 8'h00) begin
            r = {q[0], q[1] + mbs_pkg::FC_EXC_FLAG, ex};
        end else if (q[1] == mbs_pkg::FC_WR_MULTI) begin
            for (int k = 0; k < rc; k++) mem[ra + k] = {q[7 + 2 * k], q[8 + 2 * k]};
            r = q[0:5];
        end else begin
            wa = int'({q[6], q[7]});
            wc = int'({q[8], q[9]});
            for (int k = 0; k < wc; k++) mem[wa + k] = {q[11 + 2 * k], q[12 + 2 * k]};
            for (int k = 0; k < rc; k++) r = {r, 8'(mem[ra + k] >> 8), 8'(mem[ra + k])};
        end
        add_crc(r);
    endtask
    task automatic txn(input logic [7:0] q[$], input logic [7:0] ex);
        logic [7:0] got[$];
        logic [7:0] exp[$];
        mbs_master_model_inst.send_frame(q);
        mbs_master_model_inst.get_resp(got);
        model(q, ex, exp);
        `CHK(got.size(), exp.size(), "answer length")
        foreach (exp[i]) if (i < got.size()) `CHK(got[i], exp[i], "answer byte")
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // hang guard
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        logic [7:0]  q[$];
        logic [15:0] dw[$];
        logic [31:0] v;
        int          s, n;
        repeat (12) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_clock);
        // 32-bit value, high word at the lower register
        mk(8'h10, {16'h0002, 16'h0002}, {16'h0004, 16'h93E0}, 0, q);
        txn(q, 8'h00);
        dw = {};
        repeat (16) dw.push_back(16'(rnd()));
        mk(8'h10, {16'h0010, 16'h0010}, dw, 0, q);
        txn(q, 8'h00);
        // read overlaps the write of the same query
        mk(8'h17, {16'h0002, 16'h0004, 16'h0004, 16'h0002}, {16'h0000, 16'h1388}, 0, q);
        txn(q, 8'h00);
        foreach (xfc[i]) begin
            write_lock <= xlk[i];
            dw = {};
            repeat (xwc[i]) dw.push_back(16'(rnd()));
            if (xfc[i] == 8'h17) mk(xfc[i], {16'h0010, 16'h0002, xwa[i], 16'(xwc[i])}, dw, xbc[i], q);
            else mk(xfc[i], {xwa[i], 16'(xwc[i])}, dw, xbc[i], q);
            @(posedge i_clock);
            txn(q, xex[i]);
        end
        write_lock <= 1'b0;
        // broadcast, foreign address, corrupt crc
        for (int k = 0; k < 3; k++) begin
            mk(8'h10, {16'h0010, 16'h0001}, {16'hDEAD}, 0, q);
            q = q[0:q.size() - 3];
            q[0] = (k == 0) ? mbs_pkg::BCAST_ADDR : slave_addr + 8'(k == 1);
            add_crc(q);
            if (k == 2) q[q.size() - 1] ^= 8'h01;
            mbs_master_model_inst.send_frame(q);
            repeat (80) @(posedge i_clock);
            `CHK(mbs_master_model_inst.resp.size(), 0, "answer to dropped")
        end
        mk(8'h17, {16'h0010, 16'h0010, 16'h0030, 16'h0001}, {16'h1234}, 0, q);
        txn(q, 8'h00);
        for (int it = 0; it < 24; it++) begin
            v = rnd();
            slow <= v[0];
            slave_addr <= v[15:8] | 8'h01;
            n = int'(v[19:16]) + 1;
            s = int'(v[26:20]);
            @(posedge i_clock);
            dw = {};
            repeat (n) dw.push_back(16'(rnd()));
            mk(8'h10, {16'(s), 16'(n)}, dw, 0, q);
            txn(q, 8'h00);
            mk(8'h17, {16'(s), 16'(n), 16'(s + n - 1), 16'h0001}, {16'(rnd())}, 0, q);
            txn(q, 8'h00);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
